// file: design/occ_pkg.sv
package occ_pkg;

  // ---------------------------------------------------------------
  // Register map (word aligned byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OCC_ADR_OPTION = 8'h00;
  localparam logic [7:0] OCC_ADR_LSMODE = 8'h04;
  localparam logic [7:0] OCC_ADR_WDTSRC = 8'h08;
  localparam logic [7:0] OCC_ADR_STATUS = 8'h0c;

  // ---------------------------------------------------------------
  // Option byte field layout
  // ---------------------------------------------------------------
  localparam int OCC_OPT_SRC_LSB = 0;
  localparam int OCC_OPT_SRC_MSB = 1;
  localparam int OCC_OPT_LS_STOPPABLE = 2;
  localparam int OCC_OPT_RST_MODE = 3;
  localparam int OCC_OPT_WAIT_LSB = 4;
  localparam int OCC_OPT_WAIT_MSB = 5;

  // Register bit positions
  localparam int OCC_LS_STOP_BIT = 0;
  localparam int OCC_WDT_SRC_BIT = 0;

  // Reset values
  localparam logic OCC_LS_STOP_RST = 1'b0;
  localparam logic OCC_WDT_SRC_RST = 1'b0;
  localparam logic [7:0] OCC_OPT_RST = 8'h00;
  localparam logic [15:0] OCC_CNT_RST = 16'h0000;

  // Default stabilization counts, in clock cycles, per wait select
  localparam int OCC_WAIT_CYC_0 = 1024;
  localparam int OCC_WAIT_CYC_1 = 2048;
  localparam int OCC_WAIT_CYC_2 = 4096;
  localparam int OCC_WAIT_CYC_3 = 8192;

  typedef enum logic [1:0] {
    OCC_SRC_XTAL = 2'h0,
    OCC_SRC_EXT = 2'h1,
    OCC_SRC_HSINT = 2'h2,
    OCC_SRC_RSVD = 2'h3
  } occ_src_t;

  typedef enum logic [1:0] {
    OCC_ST_HOLD,
    OCC_ST_SAMPLE,
    OCC_ST_WAIT,
    OCC_ST_RUN
  } occ_state_t;

endpackage : occ_pkg

// file: design/occ_sync2.sv
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------
// Two-stage synchroniser for a pin level
// ---------------------------------------------------------------
module occ_sync2 (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic pin_sync
);

  typedef struct packed {
    logic meta;
    logic sync;
  } occ_sync_t;

  occ_sync_t s_q;
  occ_sync_t s_d;

  always_comb begin
    s_d.meta = pin_in;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_sync = s_q.sync;

endmodule : occ_sync2

`default_nettype wire

// file: design/occ_pin_mux.sv
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------
// Oscillator pin ownership against the shared port pins
// ---------------------------------------------------------------
module occ_pin_mux
  import occ_pkg::*;
(
  input wire logic cfg_valid,
  input wire logic [1:0] clk_src,
  output logic osc_in_pin_is_clk,
  output logic osc_out_pin_is_clk,
  output logic shared_port_pin_a_en,
  output logic shared_port_pin_b_en
);

  always_comb begin
    osc_in_pin_is_clk = 1'b0;
    osc_out_pin_is_clk = 1'b0;
    shared_port_pin_a_en = 1'b0;
    shared_port_pin_b_en = 1'b0;
    if (cfg_valid) begin
      case (clk_src)
        OCC_SRC_XTAL: begin
          osc_in_pin_is_clk = 1'b1;
          osc_out_pin_is_clk = 1'b1;
        end
        OCC_SRC_EXT: begin
          osc_in_pin_is_clk = 1'b1;
          shared_port_pin_b_en = 1'b1;
        end
        OCC_SRC_HSINT: begin
          shared_port_pin_a_en = 1'b1;
          shared_port_pin_b_en = 1'b1;
        end
        default: begin
          osc_in_pin_is_clk = 1'b0;
        end
      endcase
    end
  end

endmodule : occ_pin_mux

`default_nettype wire

// file: design/occ_top.sv
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Stabilization wait only with crystal source
// - No wait for internal or external clock
// - Sample option after release; low pin holds
// - Crystal source: both oscillator pins clock-only
// - External clock: first oscillator pin not port
// - Internal oscillator: both pins become ports
// - Non-stoppable: watchdog fixed to low-speed clock
// - Stoppable: watchdog clock off in HALT/STOP
// - Stoppable: watchdog off for other source
// - Low-speed running feeds interval timer in STOP
module occ_top
  import occ_pkg::*;
#(
  parameter int WAIT_CYC_0 = OCC_WAIT_CYC_0,
  parameter int WAIT_CYC_1 = OCC_WAIT_CYC_1,
  parameter int WAIT_CYC_2 = OCC_WAIT_CYC_2,
  parameter int WAIT_CYC_3 = OCC_WAIT_CYC_3
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] option_byte,
  input wire logic reset_pin_n,
  input wire logic halt_mode,
  input wire logic stop_mode,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic cpu_reset,
  output logic [1:0] sys_clk_src,
  output logic osc_in_pin_is_clk,
  output logic osc_out_pin_is_clk,
  output logic shared_port_pin_a_en,
  output logic shared_port_pin_b_en,
  output logic reset_input_port_pin,
  output logic lowspeed_osc_run,
  output logic watchdog_counter_clk_en,
  output logic watchdog_counter_src_ls,
  output logic interval_timer_clk_en
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    occ_state_t state;
    logic [7:0] opt;
    logic cfg_valid;
    logic [15:0] cnt;
    logic lowspeed_osc_stop_bit;
    logic wdt_src_other;
    logic ack;
    logic [31:0] dat;
    logic port_pin;
  } occ_regs_t;

  occ_regs_t r_q;
  occ_regs_t r_d;
  logic pin_s;
  logic [1:0] src;
  logic ls_stoppable;
  logic rst_mode;
  logic bus_req;
  logic bus_wr;

  function automatic logic [15:0] occ_wait_cycles(input logic [1:0] sel);
    logic [15:0] c;
    c = 16'(WAIT_CYC_0);
    case (sel)
      2'h1: c = 16'(WAIT_CYC_1);
      2'h2: c = 16'(WAIT_CYC_2);
      2'h3: c = 16'(WAIT_CYC_3);
      default: c = 16'(WAIT_CYC_0);
    endcase
    return c;
  endfunction : occ_wait_cycles

  occ_sync2 u_rst_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(reset_pin_n),
    .pin_sync(pin_s)
  );

  assign src = r_q.opt[OCC_OPT_SRC_MSB:OCC_OPT_SRC_LSB];
  assign ls_stoppable = r_q.opt[OCC_OPT_LS_STOPPABLE];
  assign rst_mode = r_q.opt[OCC_OPT_RST_MODE];
  assign bus_req = wb_cyc_i && wb_stb_i && !r_q.ack;
  // Writes land at the edge where the master sees ack
  assign bus_wr = wb_cyc_i && wb_stb_i && r_q.ack && wb_we_i && wb_sel_i[0];

  // ---------------------------------------------------------------
  // Sequencer and register file
  // ---------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.ack = bus_req;
    r_d.port_pin = pin_s;
    case (r_q.state)
      OCC_ST_HOLD: begin
        r_d.cfg_valid = 1'b0;
        if (pin_s) begin
          r_d.state = OCC_ST_SAMPLE;
        end
      end
      OCC_ST_SAMPLE: begin
        if (!pin_s) begin
          r_d.state = OCC_ST_HOLD;
        end else begin
          r_d.opt = option_byte;
          r_d.cfg_valid = 1'b1;
          if (option_byte[OCC_OPT_SRC_MSB:OCC_OPT_SRC_LSB] == OCC_SRC_XTAL) begin
            r_d.cnt = occ_wait_cycles(option_byte[OCC_OPT_WAIT_MSB:OCC_OPT_WAIT_LSB]);
            r_d.state = OCC_ST_WAIT;
          end else begin
            r_d.state = OCC_ST_RUN;
          end
        end
      end
      OCC_ST_WAIT: begin
        if (rst_mode && !pin_s) begin
          r_d.state = OCC_ST_HOLD;
        end else if (r_q.cnt <= 16'h0001) begin
          r_d.cnt = OCC_CNT_RST;
          r_d.state = OCC_ST_RUN;
        end else begin
          r_d.cnt = r_q.cnt - 16'h0001;
        end
      end
      OCC_ST_RUN: begin
        if (rst_mode && !pin_s) begin
          r_d.state = OCC_ST_HOLD;
        end
      end
      default: begin
        r_d.state = OCC_ST_HOLD;
      end
    endcase

    if (bus_wr) begin
      case (wb_adr_i)
        OCC_ADR_LSMODE: r_d.lowspeed_osc_stop_bit = wb_dat_i[OCC_LS_STOP_BIT];
        OCC_ADR_WDTSRC: r_d.wdt_src_other = wb_dat_i[OCC_WDT_SRC_BIT];
        default: r_d.dat = r_q.dat;
      endcase
    end

    r_d.dat = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        OCC_ADR_OPTION: r_d.dat = {24'h00_0000, r_q.opt};
        OCC_ADR_LSMODE: r_d.dat = {31'h0000_0000, r_q.lowspeed_osc_stop_bit};
        OCC_ADR_WDTSRC: r_d.dat = {31'h0000_0000, r_q.wdt_src_other};
        OCC_ADR_STATUS: r_d.dat = {24'h00_0000, interval_timer_clk_en,
          watchdog_counter_clk_en, lowspeed_osc_run, r_q.port_pin,
          r_q.cfg_valid, 1'b0, r_q.state};
        default: r_d.dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r_q.state <= OCC_ST_HOLD;
      r_q.opt <= OCC_OPT_RST;
      r_q.cfg_valid <= 1'b0;
      r_q.cnt <= OCC_CNT_RST;
      r_q.lowspeed_osc_stop_bit <= OCC_LS_STOP_RST;
      r_q.wdt_src_other <= OCC_WDT_SRC_RST;
      r_q.ack <= 1'b0;
      r_q.dat <= 32'h0000_0000;
      r_q.port_pin <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign wb_ack_o = r_q.ack;
  assign wb_dat_o = r_q.dat;
  assign cpu_reset = (r_q.state != OCC_ST_RUN);
  assign sys_clk_src = src;
  assign reset_input_port_pin = r_q.cfg_valid && !rst_mode && r_q.port_pin;

  // Non-stoppable configuration ignores the stop bit
  assign lowspeed_osc_run = !ls_stoppable || !r_q.lowspeed_osc_stop_bit;
  assign watchdog_counter_src_ls = !ls_stoppable || !r_q.wdt_src_other;
  assign watchdog_counter_clk_en = !ls_stoppable ? 1'b1
    : (lowspeed_osc_run && !halt_mode && !stop_mode
       && !r_q.wdt_src_other);
  assign interval_timer_clk_en = lowspeed_osc_run;

  occ_pin_mux u_pin_mux (
    .cfg_valid(r_q.cfg_valid),
    .clk_src(src),
    .osc_in_pin_is_clk(osc_in_pin_is_clk),
    .osc_out_pin_is_clk(osc_out_pin_is_clk),
    .shared_port_pin_a_en(shared_port_pin_a_en),
    .shared_port_pin_b_en(shared_port_pin_b_en)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_wait_xtal;
    @(posedge ref_clk) disable iff (rst)
    (r_q.state == OCC_ST_WAIT) |-> (src == OCC_SRC_XTAL);
  endproperty
  a_wait_xtal: assert property (p_wait_xtal)
    else $error("Stabilization wait without crystal source");

  property p_no_wait;
    @(posedge ref_clk) disable iff (rst)
    (r_q.state == OCC_ST_SAMPLE && pin_s
     && option_byte[OCC_OPT_SRC_MSB:OCC_OPT_SRC_LSB] != OCC_SRC_XTAL)
    |=> (r_q.state == OCC_ST_RUN) && !cpu_reset;
  endproperty
  a_no_wait: assert property (p_no_wait)
    else $error("Wait inserted for non-crystal source");

  property p_sample_hold;
    @(posedge ref_clk) disable iff (rst)
    (r_q.state == OCC_ST_SAMPLE && !pin_s) |=> (r_q.state == OCC_ST_HOLD) && cpu_reset;
  endproperty
  a_sample_hold: assert property (p_sample_hold)
    else $error("Reset released with pin low before sampling");

  property p_xtal_pins;
    @(posedge ref_clk) disable iff (rst)
    (r_q.cfg_valid && src == OCC_SRC_XTAL)
    |-> !shared_port_pin_a_en && !shared_port_pin_b_en && osc_out_pin_is_clk;
  endproperty
  a_xtal_pins: assert property (p_xtal_pins)
    else $error("Crystal pin released as port");

  property p_ext_pin;
    @(posedge ref_clk) disable iff (rst)
    (r_q.cfg_valid && src == OCC_SRC_EXT) |-> osc_in_pin_is_clk && !shared_port_pin_a_en;
  endproperty
  a_ext_pin: assert property (p_ext_pin)
    else $error("External clock pin used as port");

  property p_int_pins;
    @(posedge ref_clk) disable iff (rst)
    (r_q.cfg_valid && src == OCC_SRC_HSINT) |-> shared_port_pin_a_en && shared_port_pin_b_en;
  endproperty
  a_int_pins: assert property (p_int_pins)
    else $error("Internal oscillator pins not released");

  property p_nonstop;
    @(posedge ref_clk) disable iff (rst)
    (r_q.cfg_valid && !ls_stoppable) |-> watchdog_counter_clk_en && watchdog_counter_src_ls;
  endproperty
  a_nonstop: assert property (p_nonstop)
    else $error("Watchdog not on low-speed clock");

  property p_halt_gate;
    @(posedge ref_clk) disable iff (rst)
    (ls_stoppable && (halt_mode || stop_mode)) |-> !watchdog_counter_clk_en;
  endproperty
  a_halt_gate: assert property (p_halt_gate)
    else $error("Watchdog clock runs in standby");

  property p_src_gate;
    @(posedge ref_clk) disable iff (rst)
    (ls_stoppable && r_q.wdt_src_other) |-> !watchdog_counter_clk_en;
  endproperty
  a_src_gate: assert property (p_src_gate)
    else $error("Watchdog clock runs with other source");

  property p_tmr_stop;
    @(posedge ref_clk) disable iff (rst)
    (stop_mode && !r_q.lowspeed_osc_stop_bit) |-> interval_timer_clk_en;
  endproperty
  a_tmr_stop: assert property (p_tmr_stop)
    else $error("Interval timer clock lost in STOP");

  property p_opt_hold;
    @(posedge ref_clk) disable iff (rst)
    (r_q.cfg_valid && $past(r_q.cfg_valid)) |-> $stable(r_q.opt);
  endproperty
  a_opt_hold: assert property (p_opt_hold)
    else $error("Option fields changed after latch");

  property p_ack_pulse;
    @(posedge ref_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("Bus acknowledge longer than one cycle");

  property p_dat_idle;
    @(posedge ref_clk) disable iff (rst)
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000);
  endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("Read data outside acknowledge cycle");

  property p_port_follow;
    @(posedge ref_clk) disable iff (rst)
    (r_q.cfg_valid && !rst_mode) |-> (reset_input_port_pin == $past(pin_s));
  endproperty
  a_port_follow: assert property (p_port_follow)
    else $error("Input port level does not follow pin");

  property p_pin_rerun;
    @(posedge ref_clk) disable iff (rst)
    (r_q.state == OCC_ST_RUN && rst_mode && !pin_s)
    |=> (r_q.state == OCC_ST_HOLD) && cpu_reset;
  endproperty
  a_pin_rerun: assert property (p_pin_rerun)
    else $error("Pin reset ignored while running");

  property p_wait_count;
    @(posedge ref_clk) disable iff (rst)
    (r_q.state == OCC_ST_WAIT && r_q.cnt > 16'h0001 && !(rst_mode && !pin_s))
    |=> (r_q.state == OCC_ST_WAIT) && (r_q.cnt == $past(r_q.cnt) - 16'h0001);
  endproperty
  a_wait_count: assert property (p_wait_count)
    else $error("Stabilization count skipped a step");

  c_xtal_wait: cover property (@(posedge ref_clk) disable iff (rst)
    (r_q.state == OCC_ST_WAIT) ##1 (r_q.state == OCC_ST_RUN));
  c_direct_run: cover property (@(posedge ref_clk) disable iff (rst)
    (r_q.state == OCC_ST_SAMPLE) ##1 (r_q.state == OCC_ST_RUN));
  c_pin_hold: cover property (@(posedge ref_clk) disable iff (rst)
    (r_q.state == OCC_ST_SAMPLE) ##1 (r_q.state == OCC_ST_HOLD));
  c_stop_tmr: cover property (@(posedge ref_clk) disable iff (rst)
    stop_mode && interval_timer_clk_en && !watchdog_counter_clk_en);
  c_pin_rerun: cover property (@(posedge ref_clk) disable iff (rst)
    (r_q.state == OCC_ST_RUN) ##1 (r_q.state == OCC_ST_HOLD));

endmodule : occ_top

`default_nettype wire

// file: tb/option_clock_reset_config_bench.sv
`timescale 1ns/1ns
`default_nettype none
module option_clock_reset_config_bench;
  import occ_pkg::*;
  int wait_tab[4] = '{4, 5, 6, 7};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] option_byte = 8'h02;
  logic reset_pin_n = 1'b1;
  logic halt_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_ack_o, cpu_reset, osc_in_pin_is_clk, osc_out_pin_is_clk;
  logic shared_port_pin_a_en, shared_port_pin_b_en, reset_input_port_pin;
  logic lowspeed_osc_run, watchdog_counter_clk_en, watchdog_counter_src_ls;
  logic interval_timer_clk_en;
  logic [31:0] wb_dat_o;
  logic [1:0] sys_clk_src;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] lfsr_q = 32'h000107d3;
  logic [7:0] m_opt;
  logic m_stop, m_wsrc;

  occ_top #(.WAIT_CYC_0(4), .WAIT_CYC_1(5), .WAIT_CYC_2(6), .WAIT_CYC_3(7)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .option_byte(option_byte), .reset_pin_n(reset_pin_n),
    .halt_mode(halt_mode), .stop_mode(stop_mode), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .cpu_reset(cpu_reset), .sys_clk_src(sys_clk_src),
    .osc_in_pin_is_clk(osc_in_pin_is_clk), .osc_out_pin_is_clk(osc_out_pin_is_clk),
    .shared_port_pin_a_en(shared_port_pin_a_en), .shared_port_pin_b_en(shared_port_pin_b_en),
    .reset_input_port_pin(reset_input_port_pin), .lowspeed_osc_run(lowspeed_osc_run),
    .watchdog_counter_clk_en(watchdog_counter_clk_en),
    .watchdog_counter_src_ls(watchdog_counter_src_ls),
    .interval_timer_clk_en(interval_timer_clk_en));

  always #5 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checked %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      stop_test();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // ---------------------------------------------------------------
  // Wishbone classic master
  // ---------------------------------------------------------------
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         input logic [3:0] sel, output logic [31:0] rdat);
    int n;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    check(n, 32'd2, "ack latency");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_xfer

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string msg);
    logic [31:0] d;
    wb_xfer(1'b0, adr, 32'h0, 4'hf, d);
    check(d, exp, msg);
  endtask : rd_chk

  task automatic wait_run(output int n);
    n = 0;
    while (cpu_reset !== 1'b0 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_run

  task automatic boot(input logic [7:0] opt, output int n);
    @(posedge ref_clk);
    rst <= 1'b1;
    option_byte <= opt;
    m_opt = opt;
    m_stop = 1'b0;
    m_wsrc = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    wait_run(n);
  endtask : boot

  // Model of pin ownership and low-speed clock gating
  task automatic check_model();
    logic stp, run;
    logic [3:0] pins;
    stp = m_opt[2];
    run = !stp || !m_stop;
    case (m_opt[1:0])
      2'h0: pins = 4'hc;
      2'h1: pins = 4'h9;
      2'h2: pins = 4'h3;
      default: pins = 4'h0;
    endcase
    check(sys_clk_src, m_opt[1:0], "clock source");
    check({osc_in_pin_is_clk, osc_out_pin_is_clk}, pins[3:2], "osc pins");
    check({shared_port_pin_a_en, shared_port_pin_b_en}, pins[1:0], "port pins");
    check(lowspeed_osc_run, run, "ls run");
    check(watchdog_counter_clk_en, !stp || (run && !halt_mode && !stop_mode && !m_wsrc),
          "wdt clock");
    check(watchdog_counter_src_ls, !stp || !m_wsrc, "wdt src");
    check(interval_timer_clk_en, run, "timer clock");
  endtask : check_model

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int n, n_hs, i;
    logic [7:0] opt;
    logic [31:0] d;
    static logic [1:0] srcs[4] = '{2'h2, 2'h1, 2'h0, 2'h3};
    for (i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      opt = {2'h0, lfsr_q[1:0], 1'b1, lfsr_q[2], srcs[i]};
      boot(opt, n);
      if (i == 0) n_hs = n;
      if (i == 0) check(n <= 8, 1'b1, "no wait");
      if (i == 1) check(n, n_hs, "ext no wait");
      if (i == 2) check(n >= n_hs + wait_tab[opt[5:4]] && n <= n_hs + wait_tab[opt[5:4]] + 1,
                        1'b1, "crystal wait");
      rd_chk(OCC_ADR_LSMODE, 32'h0, "lsmode reset");
      rd_chk(OCC_ADR_WDTSRC, 32'h0, "wdtsrc reset");
      option_byte <= ~opt;
      check_model();
      rd_chk(OCC_ADR_OPTION, {24'h0, opt}, "latched option");
      check_model();
      $display("test source %0d done", i);
    end

    for (int stp = 0; stp < 2; stp++) begin
      boot({5'h01, stp[0], 2'h2}, n);
      for (i = 0; i < 16; i++) begin
        lfsr_q = lfsr_next(lfsr_q);
        m_stop = i[3];
        m_wsrc = i[2];
        wb_xfer(1'b1, OCC_ADR_LSMODE, {lfsr_q[31:1], m_stop}, 4'hf, d);
        wb_xfer(1'b1, OCC_ADR_WDTSRC, {lfsr_q[30:0], m_wsrc}, 4'hf, d);
        halt_mode <= i[1];
        stop_mode <= i[0];
        @(posedge ref_clk);
        check_model();
        rd_chk(OCC_ADR_LSMODE, {31'h0, m_stop}, "lsmode readback");
        rd_chk(OCC_ADR_WDTSRC, {31'h0, m_wsrc}, "wdtsrc readback");
      end
      halt_mode <= 1'b0;
      stop_mode <= 1'b0;
      $display("test gating %0d done", stp);
    end

    wb_xfer(1'b1, OCC_ADR_LSMODE, 32'h0, 4'he, d);
    rd_chk(OCC_ADR_LSMODE, 32'h1, "sel0 low write ignored");
    wb_xfer(1'b1, 8'h10, 32'hffffffff, 4'hf, d);
    rd_chk(8'h10, 32'h0, "unmapped read");
    $display("test refusals done");

    reset_pin_n <= 1'b0;
    boot(8'h0a, n);
    check(cpu_reset, 1'b1, "held by pin");
    option_byte <= 8'h06;
    reset_pin_n <= 1'b1;
    m_opt = 8'h06;
    wait_run(n);
    check(n < 100, 1'b1, "runs after pin high");
    rd_chk(OCC_ADR_OPTION, 32'h06, "option sampled late");
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check({cpu_reset, reset_input_port_pin}, 2'h0, "port low");
    reset_pin_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check({cpu_reset, reset_input_port_pin}, 2'h1, "port high");
    rd_chk(OCC_ADR_STATUS, 32'hfb, "status word");
    boot(8'h0a, n);
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check({cpu_reset, reset_input_port_pin}, 2'h2, "pin reset in run");
    reset_pin_n <= 1'b1;
    wait_run(n);
    check(n < 100, 1'b1, "rerun after pin reset");
    $display("test reset pin done");
    stop_test();
  end
endmodule : option_clock_reset_config_bench
`default_nettype wire
